//--- rtl/otpsec_consts.svh
`ifndef OTPSEC_CONSTS_SVH
`define OTPSEC_CONSTS_SVH
// Register byte offsets
`define OTPSEC_SEC_CFG_OFS 8'h00
`define OTPSEC_ADDR_OFS 8'h04
`define OTPSEC_WDATA_OFS 8'h08
`define OTPSEC_CTRL_OFS 8'h0C
`define OTPSEC_STATUS_OFS 8'h10
`define OTPSEC_RDATA_OFS 8'h14
// Security field positions
`define OTPSEC_JTAG_DIS_BIT 0
`define OTPSEC_LINK_DIS_BIT 1
`define OTPSEC_SEC_BOOT_BIT 5
`define OTPSEC_REDUND_BIT 7
`define OTPSEC_SLOCK_LSB 8
`define OTPSEC_MLOCK_BIT 12
`define OTPSEC_JTAG_OTP_DIS_BIT 13
`define OTPSEC_GP_LSB 15
`define OTPSEC_GP_MSB 21
`define OTPSEC_UID_LSB 22
`define OTPSEC_UID_MSB 31
// Control bits
`define OTPSEC_CTRL_PROG_BIT 0
`define OTPSEC_CTRL_READ_BIT 1
`define OTPSEC_CTRL_CLR_BIT 2
// Row holding the security word, last row of sector 3
`define OTPSEC_SEC_ROW 11'h7FF
// Reset values
`define OTPSEC_SEC_RST 32'h00000000
`define OTPSEC_ADDR_RST 16'h0000
`define OTPSEC_WDATA_RST 32'h00000000
// Program pulse length in clock cycles
`define OTPSEC_PROG_CYCLES 5'h10
`endif

//--- rtl/otpsec_pkg.sv
package otpsec_pkg;
  typedef enum logic [2:0] {
    ST_LOAD_SEC,
    ST_COPY,
    ST_IDLE,
    ST_PROG,
    ST_READ
  } otpsec_state_t;
  typedef logic [10:0] otpsec_row_t;
endpackage : otpsec_pkg

//--- rtl/otpsec_array.sv
`timescale 1ns/100ps
module otpsec_array #(
  parameter int SECTORS = 4,
  parameter int ROWS = 512,
  parameter int WIDTH = 32,
  parameter int AW = 11
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low; no burn while low
  input wire logic [AW-1:0] rd_addr, // Read row
  output logic [WIDTH-1:0] rd_data, // Read word, combinational
  input wire logic redund_en, // Merge redundant copy on read
  input wire logic wr_en, // Program pulse
  input wire logic [AW-1:0] wr_addr, // Program row
  input wire logic [WIDTH-1:0] wr_data // Bits to set
);
  localparam int DEPTH = SECTORS * ROWS;
  logic [WIDTH-1:0] prim_mem [DEPTH];
  logic [WIDTH-1:0] spare_mem [DEPTH];
  // Blank only at power-up: fuses must survive presetn like real OTP
  logic [DEPTH-1:0] used_q = '0;
  wire [WIDTH-1:0] prim_w = used_q[rd_addr] ? prim_mem[rd_addr] : '0;
  wire [WIDTH-1:0] spare_w = used_q[rd_addr] ? spare_mem[rd_addr] : '0;
  wire [WIDTH-1:0] old_w = used_q[wr_addr] ? prim_mem[wr_addr] : '0;

  // Fuses only ever go from 0 to 1; a per-row flag stands in for blank rows
  always_ff @(posedge clk)
  begin
    if (wr_en && rst_n)
    begin
      prim_mem[wr_addr] <= old_w | wr_data;
      spare_mem[wr_addr] <= old_w | wr_data;
      used_q[wr_addr] <= 1'b1;
    end
  end

  // Spare copy masks a weak bit in the primary row
  assign rd_data = redund_en ? (prim_w | spare_w) : prim_w; // (RQ4)
endmodule : otpsec_array

//--- rtl/otpsec_top.sv
// Function
// (RQ1) Security bit 0 blocks all JTAG access to tile state and memory.
// (RQ2) Security bit 1 rejects switch requests from other tiles to processor state.
// (RQ3) Security bit 5 forces boot from OTP address zero, ignoring straps.
// (RQ4) Security bit 7 enables the redundant OTP rows.
// (RQ5) Bits 8 to 11 each lock programming of the matching sector.
// (RQ6) Bit 12 refuses all OTP programming, sectors and security word alike.
// (RQ7) Bit 13 denies JTAG reads and writes of the OTP.
// (RQ8) Bits 21 to 15 are a software field with no hardware effect.
// (RQ9) Bits 31 to 22 hold the user identifier extension.
// (RQ10) OTP holds four sectors of 512 rows, 32 bits each.
// (RQ11) Security word is loaded from OTP before any feature takes effect.
// (RQ12) Other OTP rows are copied to SRAM and run first.
// (RQ13) Software gives the row address through a 16-bit port.
// (RQ14) Software gives program data through a 32-bit port.
// (RQ15) Software drives OTP operations through a 16-bit control port.
// (RQ16) User code readout returns bits 22 to 31, zero when unprogrammed.
// (RQ17) Programs aimed at locked sectors leave OTP contents unchanged.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "otpsec_consts.svh"
module otpsec_top (
  input wire logic pclk, // APB clock, 25 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [2:0] boot_strap_pin, // Boot source strap pins
  output logic boot_valid, // Boot decision made, level
  output logic boot_from_otp, // Boot from OTP address zero
  output logic [2:0] boot_source, // Captured strap value
  output logic sram_we, // SRAM write strobe during copy
  output logic [10:0] sram_addr, // SRAM word address
  output logic [31:0] sram_wdata, // SRAM write data
  input wire logic jtag_dbg_req, // JTAG debug access request
  output logic jtag_dbg_grant, // JTAG debug access allowed
  input wire logic link_req, // Switch request to processor state
  output logic link_grant, // Switch request accepted
  output logic link_reject, // Switch request refused
  input wire logic jtag_otp_req, // JTAG OTP access request, pulse
  input wire logic jtag_otp_we, // JTAG OTP program when high
  input wire logic [10:0] jtag_otp_addr, // JTAG OTP row
  input wire logic [31:0] jtag_otp_wdata, // JTAG OTP program data
  output logic jtag_otp_ack, // JTAG OTP access done, pulse
  output logic jtag_otp_denied, // JTAG OTP access refused, pulse
  output logic [31:0] jtag_otp_rdata, // JTAG OTP read data
  output logic [9:0] usercode_id // JTAG user code identifier field
);
  otpsec_pkg::otpsec_state_t state_q, state_d;
  logic [31:0] sec_q;
  logic sec_loaded_q;
  logic [15:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic refused_q;
  logic [10:0] copy_q;
  logic [4:0] cnt_q;
  logic op_jtag_q;
  logic op_we_q;
  logic [10:0] op_addr_q;
  logic [31:0] op_wdata_q;
  logic [2:0] strap_s1_q, strap_s2_q;
  logic [2:0] boot_src_q;
  logic boot_valid_q, boot_otp_q;
  logic sram_we_q;
  logic [10:0] sram_addr_q;
  logic [31:0] sram_wdata_q;
  logic jack_q, jden_q;
  logic [31:0] jrdata_q;
  logic [31:0] arr_rdata;
  logic [10:0] arr_raddr;

  // APB decode
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  wire sel_sec = paddr == `OTPSEC_SEC_CFG_OFS;
  wire sel_addr = paddr == `OTPSEC_ADDR_OFS;
  wire sel_wdata = paddr == `OTPSEC_WDATA_OFS;
  wire sel_ctrl = paddr == `OTPSEC_CTRL_OFS;
  wire sel_stat = paddr == `OTPSEC_STATUS_OFS;
  wire sel_rdata = paddr == `OTPSEC_RDATA_OFS;
  wire mapped = sel_sec | sel_addr | sel_wdata | sel_ctrl | sel_stat | sel_rdata;
  wire idle = state_q == otpsec_pkg::ST_IDLE;
  wire busy = ~idle;

  // Security controls; the JTAG and link grants are closed until the word has been loaded
  wire jtag_ok = sec_loaded_q & ~sec_q[`OTPSEC_JTAG_DIS_BIT]; // (RQ1) (RQ11)
  wire link_ok = sec_loaded_q & ~sec_q[`OTPSEC_LINK_DIS_BIT]; // (RQ2) (RQ11)
  wire jtag_otp_ok = jtag_ok & ~sec_q[`OTPSEC_JTAG_OTP_DIS_BIT]; // (RQ7)
  wire redund_en = sec_q[`OTPSEC_REDUND_BIT]; // (RQ4)
  wire [3:0] sector_lock = sec_q[`OTPSEC_SLOCK_LSB +: 4];
  wire master_lock = sec_q[`OTPSEC_MLOCK_BIT];

  // Software operations from the control port
  wire ctrl_wr = apb_wr & sel_ctrl; // (RQ15)
  wire sw_prog = ctrl_wr & pwdata[`OTPSEC_CTRL_PROG_BIT];
  wire sw_read = ctrl_wr & pwdata[`OTPSEC_CTRL_READ_BIT] & ~sw_prog;
  wire sw_clr = ctrl_wr & pwdata[`OTPSEC_CTRL_CLR_BIT];
  // Row address beyond the array is refused for programs and reads alike
  wire sw_range = addr_q[15:11] == 5'h00; // (RQ10) (RQ13)
  wire sw_op = idle & (sw_prog | sw_read);
  // Software takes priority; JTAG retries on a denied pulse
  wire jtag_try = idle & jtag_otp_req & ~sw_op;
  wire jtag_take = jtag_try & jtag_otp_ok; // (RQ7)
  wire jtag_deny = (jtag_otp_req & ~jtag_otp_ok) | (jtag_otp_req & ~idle) |
                   (jtag_otp_req & sw_op);

  // Sector is bits 10:9 of the row; the security row sits in sector 3
  wire [10:0] req_addr = jtag_take ? jtag_otp_addr : addr_q[10:0];
  wire req_we = jtag_take ? jtag_otp_we : sw_prog;
  wire req_range = jtag_take | sw_range;
  wire req_locked = master_lock | sector_lock[req_addr[10:9]]; // (RQ5) (RQ6)
  wire prog_refuse = (sw_op | jtag_take) & req_we & (req_locked | ~req_range); // (RQ17)
  wire read_refuse = sw_op & ~req_we & ~req_range;
  wire start_op = (sw_op | jtag_take) & ~prog_refuse & ~read_refuse;
  wire prog_done = state_q == otpsec_pkg::ST_PROG && cnt_q == `OTPSEC_PROG_CYCLES;
  wire arr_we = prog_done; // (RQ17)
  wire copy_last = copy_q == `OTPSEC_SEC_ROW - 11'h001;

  assign arr_raddr = state_q == otpsec_pkg::ST_LOAD_SEC ? `OTPSEC_SEC_ROW :
                     state_q == otpsec_pkg::ST_COPY ? copy_q : op_addr_q;

  otpsec_array #(
    .SECTORS(4),
    .ROWS(512),
    .WIDTH(32),
    .AW(11)
  ) u_array (
    .clk(pclk),
    .rst_n(presetn),
    .rd_addr(arr_raddr),
    .rd_data(arr_rdata),
    .redund_en(redund_en),
    .wr_en(arr_we),
    .wr_addr(op_addr_q),
    .wr_data(op_wdata_q)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      otpsec_pkg::ST_LOAD_SEC: state_d = otpsec_pkg::ST_COPY; // (RQ11)
      otpsec_pkg::ST_COPY:
        if (copy_last)
          state_d = otpsec_pkg::ST_IDLE; // (RQ12)
      otpsec_pkg::ST_IDLE:
        if (start_op)
          state_d = req_we ? otpsec_pkg::ST_PROG : otpsec_pkg::ST_READ;
      otpsec_pkg::ST_PROG:
        if (prog_done)
          state_d = otpsec_pkg::ST_IDLE;
      otpsec_pkg::ST_READ: state_d = otpsec_pkg::ST_IDLE;
      default: state_d = otpsec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= otpsec_pkg::ST_LOAD_SEC;
    else
      state_q <= state_d;
  end

  // Security word: loaded once; only the software field is writable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_q <= `OTPSEC_SEC_RST;
      sec_loaded_q <= 1'b0;
    end
    else if (state_q == otpsec_pkg::ST_LOAD_SEC)
    begin
      sec_q <= arr_rdata; // (RQ11)
      sec_loaded_q <= 1'b1;
    end
    else if (apb_wr & sel_sec)
      sec_q[`OTPSEC_GP_MSB:`OTPSEC_GP_LSB] <= pwdata[`OTPSEC_GP_MSB:`OTPSEC_GP_LSB]; // (RQ8)
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_q <= `OTPSEC_ADDR_RST;
      wdata_q <= `OTPSEC_WDATA_RST;
    end
    else
    begin
      if (apb_wr & sel_addr)
        addr_q <= pwdata[15:0]; // (RQ13)
      if (apb_wr & sel_wdata)
        wdata_q <= pwdata; // (RQ14)
    end
  end

  // Refused flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refused_q <= 1'b0;
    else if (prog_refuse | read_refuse)
      refused_q <= 1'b1;
    else if (sw_clr)
      refused_q <= 1'b0;
  end

  // Operation latch and program pulse timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_jtag_q <= 1'b0;
      op_we_q <= 1'b0;
      op_addr_q <= 11'h000;
      op_wdata_q <= 32'h00000000;
      cnt_q <= 5'h00;
    end
    else if (start_op)
    begin
      op_jtag_q <= jtag_take;
      op_we_q <= req_we;
      op_addr_q <= req_addr;
      op_wdata_q <= jtag_take ? jtag_otp_wdata : wdata_q; // (RQ14)
      cnt_q <= 5'h00;
    end
    else if (state_q == otpsec_pkg::ST_PROG)
      cnt_q <= cnt_q + 5'h01;
  end

  // Read result for software, JTAG answers on its own port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h00000000;
      jrdata_q <= 32'h00000000;
      jack_q <= 1'b0;
      jden_q <= 1'b0;
    end
    else
    begin
      jack_q <= (state_q == otpsec_pkg::ST_READ | prog_done) & op_jtag_q;
      jden_q <= jtag_deny | (jtag_take & prog_refuse); // (RQ7) (RQ17)
      if (state_q == otpsec_pkg::ST_READ && !op_jtag_q)
        rdata_q <= arr_rdata;
      if (state_q == otpsec_pkg::ST_READ && op_jtag_q)
        jrdata_q <= arr_rdata; // (RQ7)
    end
  end

  // Copy of rows below the security row into SRAM
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      copy_q <= 11'h000;
      sram_we_q <= 1'b0;
      sram_addr_q <= 11'h000;
      sram_wdata_q <= 32'h00000000;
    end
    else
    begin
      sram_we_q <= state_q == otpsec_pkg::ST_COPY; // (RQ12)
      sram_addr_q <= copy_q;
      sram_wdata_q <= arr_rdata;
      if (state_q == otpsec_pkg::ST_COPY)
        copy_q <= copy_q + 11'h001;
    end
  end

  // Straps come from pins, two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end
    else
    begin
      strap_s1_q <= boot_strap_pin;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Boot decision is taken on the last copy row, in the same cycle as its SRAM write strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_valid_q <= 1'b0;
      boot_otp_q <= 1'b0;
      boot_src_q <= 3'h0;
    end
    else if (state_q == otpsec_pkg::ST_COPY && copy_last)
    begin
      boot_valid_q <= 1'b1; // (RQ12)
      boot_otp_q <= sec_q[`OTPSEC_SEC_BOOT_BIT]; // (RQ3)
      boot_src_q <= strap_s2_q;
    end
  end

  // APB answers in the first access cycle
  wire [31:0] status_w = {28'h0000000, boot_otp_q, refused_q, sec_loaded_q, busy};
  assign prdata = ~apb_rd ? 32'h00000000 :
                  sel_sec ? sec_q :
                  sel_addr ? {16'h0000, addr_q} :
                  sel_wdata ? wdata_q :
                  sel_stat ? status_w :
                  sel_rdata ? rdata_q : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  assign boot_valid = boot_valid_q;
  assign boot_from_otp = boot_otp_q; // (RQ3)
  assign boot_source = boot_src_q;
  assign sram_we = sram_we_q;
  assign sram_addr = sram_addr_q;
  assign sram_wdata = sram_wdata_q;
  assign jtag_dbg_grant = jtag_dbg_req & jtag_ok; // (RQ1)
  assign link_grant = link_req & link_ok; // (RQ2)
  assign link_reject = link_req & ~link_ok; // (RQ2)
  assign jtag_otp_ack = jack_q;
  assign jtag_otp_denied = jden_q;
  assign jtag_otp_rdata = jrdata_q;
  assign usercode_id = sec_q[`OTPSEC_UID_MSB:`OTPSEC_UID_LSB]; // (RQ9) (RQ16)
endmodule : otpsec_top

//--- sim/otpsec_top_sva.sv
`timescale 1ns/100ps
module otpsec_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic boot_valid, // Boot decided
  input wire logic boot_from_otp, // Secure boot
  input wire logic [2:0] boot_source, // Straps
  input wire logic sram_we, // Copy strobe
  input wire logic [10:0] sram_addr, // Copy row
  input wire logic jtag_dbg_req, // Debug request
  input wire logic jtag_dbg_grant, // Debug grant
  input wire logic link_req, // Link request
  input wire logic link_grant, // Link grant
  input wire logic link_reject, // Link refusal
  input wire logic jtag_otp_req, // OTP request
  input wire logic jtag_otp_ack, // OTP done
  input wire logic jtag_otp_denied, // OTP refused
  input wire logic [9:0] usercode_id // User code
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [11:0] we_cnt_q;
  logic [11:0] we_cnt_d;
  assign we_cnt_d = sram_we ? we_cnt_q + 12'h001 : we_cnt_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      we_cnt_q <= 12'h000;
    else
      we_cnt_q <= we_cnt_d;
  sequence otp_reply;
    jtag_otp_ack || jtag_otp_denied;
  endsequence
  sequence sec_read;
    psel && penable && !pwrite && paddr == 8'h00;
  endsequence
  dbg_gate_a: assert property (jtag_dbg_grant |-> jtag_dbg_req)
    else $error("debug grant without request");
  link_gate_a: assert property (link_grant |-> link_req && !link_reject)
    else $error("link grant inconsistent");
  boot_early_a: assert property (!boot_valid |-> !boot_from_otp)
    else $error("secure boot before load");
  boot_hold_a: assert property (boot_valid |=> boot_valid && $stable(boot_source)
    && $stable(boot_from_otp))
    else $error("boot decision changed");
  copy_row_a: assert property (sram_we |-> sram_addr == we_cnt_q[10:0])
    else $error("copy row out of order");
  copy_len_a: assert property ($fell(sram_we) |-> we_cnt_q == 12'h7FF)
    else $error("copy length wrong");
  otp_reply_a: assert property (jtag_otp_req |-> ##[1:24] otp_reply)
    else $error("jtag otp request unanswered");
  reply_pulse_a: assert property (otp_reply |=> !jtag_otp_ack && !jtag_otp_denied)
    else $error("jtag otp answer too long");
  uid_blank_a: assert property ($rose(presetn) |-> usercode_id == 10'h000)
    else $error("user code not blank before load");
  uid_hold_a: assert property (boot_valid |=> $stable(usercode_id))
    else $error("user code changed after load");
  uid_read_a: assert property (sec_read |-> prdata[31:22] == usercode_id)
    else $error("user code field mismatch");
endmodule : otpsec_chk
bind otpsec_top otpsec_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .boot_valid(boot_valid), .boot_from_otp(boot_from_otp), .boot_source(boot_source),
  .sram_we(sram_we), .sram_addr(sram_addr), .jtag_dbg_req(jtag_dbg_req),
  .jtag_dbg_grant(jtag_dbg_grant), .link_req(link_req), .link_grant(link_grant),
  .link_reject(link_reject), .jtag_otp_req(jtag_otp_req), .jtag_otp_ack(jtag_otp_ack),
  .jtag_otp_denied(jtag_otp_denied), .usercode_id(usercode_id));

//--- sim/otpsec_jtag_host.sv
`timescale 1ns/100ps
module otpsec_jtag_host (
  input wire logic clk, // Clock
  output logic req, // Request pulse
  output logic we, // Program
  output logic [10:0] addr, // Row
  output logic [31:0] wdata, // Data
  input wire logic ack, // Done
  input wire logic denied, // Refused
  input wire logic [31:0] rdata // Read word
);
  initial
  begin
    req = 1'b0;
    we = 1'b0;
    addr = 11'h000;
    wdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [10:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] res);
    int i;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    // Stale qualifiers must not look valid
    we <= ~w;
    addr <= ~a;
    wdata <= ~d;
    res = 2'h0;
    for (i = 0; i < 40 && res == 2'h0; i++)
    begin
      @(posedge clk);
      res = {denied, ack};
      q = rdata;
    end
  endtask : xfer
endmodule : otpsec_jtag_host

//--- sim/otp_security_register_control_test.sv
`timescale 1ns/100ps
`include "otpsec_consts.svh"
module otp_security_register_control_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, sram_wdata, wdata, rdata, rdv, q, wd_or;
  logic boot_valid, boot_from_otp, sram_we, jtag_dbg_req, jtag_dbg_grant;
  logic link_req, link_grant, link_reject, req, we, ack, denied, errv;
  logic [2:0] boot_source;
  logic [10:0] sram_addr, addr;
  logic [9:0] usercode_id;
  logic [1:0] res;
  int errors, check_count, copies;
  otpsec_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_strap_pin(3'h5), .boot_valid(boot_valid),
    .boot_from_otp(boot_from_otp), .boot_source(boot_source), .sram_we(sram_we),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .jtag_dbg_req(jtag_dbg_req),
    .jtag_dbg_grant(jtag_dbg_grant), .link_req(link_req), .link_grant(link_grant),
    .link_reject(link_reject), .jtag_otp_req(req), .jtag_otp_we(we),
    .jtag_otp_addr(addr), .jtag_otp_wdata(wdata), .jtag_otp_ack(ack),
    .jtag_otp_denied(denied), .jtag_otp_rdata(rdata), .usercode_id(usercode_id));
  otpsec_jtag_host host (.clk(pclk), .req(req), .we(we), .addr(addr), .wdata(wdata),
    .ack(ack), .denied(denied), .rdata(rdata));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bound(input int i, input int n);
    if (i >= n)
    begin
      errors++;
      conclude();
    end
  endtask : bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    bound(i, 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic idle;
    int i;
    for (i = 0; i < 100; i++)
    begin
      apb(1'b0, `OTPSEC_STATUS_OFS, 32'h0);
      if (rdv[0] === 1'b0)
        break;
    end
    bound(i, 100);
  endtask : idle
  task automatic wait_boot;
    int i;
    for (i = 0; i < 3000 && boot_valid !== 1'b1; i++)
      @(posedge pclk);
    bound(i, 3000);
    // One more edge so the copy monitor has counted the last row
    @(posedge pclk);
  endtask : wait_boot
  task automatic restart;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    {copies, wd_or} = '0;
    presetn <= 1'b1;
    wait_boot();
  endtask : restart
  task automatic burn(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, `OTPSEC_ADDR_OFS, a);
    apb(1'b1, `OTPSEC_WDATA_OFS, d);
    apb(1'b1, `OTPSEC_CTRL_OFS, 32'h1);
    idle();
  endtask : burn
  task automatic rd_row(input logic [31:0] a);
    apb(1'b1, `OTPSEC_ADDR_OFS, a);
    apb(1'b1, `OTPSEC_CTRL_OFS, 32'h2);
    idle();
    apb(1'b0, `OTPSEC_RDATA_OFS, 32'h0);
  endtask : rd_row
  task automatic t_boot;
    host.xfer(1'b0, 11'h000, 32'h0, q, res);
    check({30'h0, res}, 32'h2);
    wait_boot();
    check(copies, 32'h7FF);
    check(wd_or, 32'h0);
    check({28'h0, boot_from_otp, boot_source}, 32'h5);
    check({30'h0, jtag_dbg_grant, link_grant}, 32'h3);
  endtask : t_boot
  task automatic t_regs;
    apb(1'b0, `OTPSEC_SEC_CFG_OFS, 32'h0);
    check(rdv, 32'h0);
    apb(1'b1, `OTPSEC_SEC_CFG_OFS, 32'hFFFFFFFF);
    apb(1'b0, `OTPSEC_SEC_CFG_OFS, 32'h0);
    check(rdv, 32'h003F8000);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, errv}, 32'h1);
  endtask : t_regs
  task automatic t_prog;
    apb(1'b1, `OTPSEC_ADDR_OFS, 32'h00000200);
    apb(1'b1, `OTPSEC_WDATA_OFS, 32'h12345670);
    apb(1'b1, `OTPSEC_CTRL_OFS, 32'h1);
    idle();
    apb(1'b1, `OTPSEC_WDATA_OFS, 32'h0000000F);
    apb(1'b1, `OTPSEC_CTRL_OFS, 32'h1);
    idle();
    apb(1'b1, `OTPSEC_CTRL_OFS, 32'h2);
    idle();
    apb(1'b0, `OTPSEC_RDATA_OFS, 32'h0);
    check(rdv, 32'h1234567F);
    apb(1'b1, `OTPSEC_ADDR_OFS, 32'h00000800);
    apb(1'b1, `OTPSEC_CTRL_OFS, 32'h1);
    apb(1'b0, `OTPSEC_STATUS_OFS, 32'h0);
    check(rdv & 32'h7, 32'h6);
    apb(1'b1, `OTPSEC_CTRL_OFS, 32'h4);
    apb(1'b0, `OTPSEC_STATUS_OFS, 32'h0);
    check(rdv & 32'h7, 32'h2);
  endtask : t_prog
  task automatic t_jtag;
    host.xfer(1'b0, 11'h200, 32'h0, q, res);
    check(q, 32'h1234567F);
    check({30'h0, res}, 32'h1);
    host.xfer(1'b1, 11'h7FF, 32'hA5A50000, q, res);
    check({30'h0, res}, 32'h1);
    host.xfer(1'b0, 11'h7FF, 32'h0, q, res);
    check(q, 32'hA5A50000);
    check({30'h0, res}, 32'h1);
    jtag_dbg_req <= 1'b0;
    link_req <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    check({30'h0, jtag_dbg_grant, link_grant}, 32'h0);
  endtask : t_jtag
  task automatic t_lock;
    burn(32'h000007FF, 32'h000022A2);
    jtag_dbg_req <= 1'b1;
    link_req <= 1'b1;
    restart();
    check(copies, 32'h7FF);
    check(wd_or, 32'h1234567F);
    check({31'h0, boot_from_otp}, 32'h1);
    check({30'h0, link_grant, link_reject}, 32'h1);
    check({31'h0, jtag_dbg_grant}, 32'h1);
    check({22'h0, usercode_id}, 32'h296);
    apb(1'b0, `OTPSEC_SEC_CFG_OFS, 32'h0);
    check(rdv, 32'hA5A522A2);
    host.xfer(1'b0, 11'h200, 32'h0, q, res);
    check({30'h0, res}, 32'h2);
    burn(32'h00000200, 32'h80000000);
    check(rdv & 32'h7, 32'h6);
    rd_row(32'h00000200);
    check(rdv, 32'h1234567F);
    apb(1'b1, `OTPSEC_CTRL_OFS, 32'h4);
    burn(32'h00000000, 32'h00000001);
    check(rdv & 32'h7, 32'h2);
    rd_row(32'h00000000);
    check(rdv, 32'h00000001);
    burn(32'h000007FF, 32'h00001001);
    restart();
    check({31'h0, jtag_dbg_grant}, 32'h0);
    host.xfer(1'b0, 11'h000, 32'h0, q, res);
    check({30'h0, res}, 32'h2);
    burn(32'h000007FF, 32'h00000002);
    check(rdv & 32'h7, 32'h6);
  endtask : t_lock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (sram_we === 1'b1)
    begin
      copies++;
      wd_or = wd_or | sram_wdata;
    end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {jtag_dbg_req, link_req, errors, check_count, copies, wd_or} = '0;
    jtag_dbg_req = 1'b1;
    link_req = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    check({31'h0, jtag_dbg_grant}, 32'h0);
    t_boot();
    t_regs();
    t_prog();
    t_jtag();
    t_lock();
    conclude();
  end
endmodule : otp_security_register_control_test
